/* rtl/nibble_swap_xor_dir_exec.v */
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.vh"

module nibble_swap_xor_dir_exec
#(
  parameter WIDTH = 8
)
(
  input  wire              clk,
  input  wire              rstn,
  input  wire              insn_valid,
  input  wire [`INSN_W-1:0] insn,
  input  wire [WIDTH-1:0]  file_rdata,
  output reg  [6:0]        file_addr,
  output reg               file_rd,
  output reg               file_we,
  output reg  [WIDTH-1:0]  file_wdata,
  output reg  [WIDTH-1:0]  acc,
  output reg               zero_flag,
  output reg  [WIDTH-1:0]  dir_a,
  output reg  [WIDTH-1:0]  dir_b,
  output reg  [WIDTH-1:0]  dir_c,
  output reg  [1:0]        phase,
  output reg               busy,
  output reg               illegal
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  reg  [`INSN_W-1:0] cur;
  wire [5:0]         opc = cur[`OPC_HI:`OPC_LO];
  wire [2:0]         dsel = cur[`DIR_SEL_HI:`DIR_SEL_LO];
  wire               is_swap = (opc == `OPC_NIBBLE_EXCHANGE);
  wire               is_xorf = (opc == `OPC_XOR_FILE);
  wire               is_xorl = (opc == `OPC_XOR_LITERAL);
  // legacy form still decodes so older code keeps working
  wire               is_dirl = (cur[`DIR_LOAD_HI:`DIR_LOAD_LO] ==
                                `DIR_LOAD_PATTERN) &&
                               (dsel >= `DIR_SEL_FIRST);
  wire               to_file = cur[`DEST_BIT];
  wire [6:0]         faddr = cur[`FADDR_HI:`FADDR_LO];

  reg  [WIDTH-1:0]   operand;
  reg  [WIDTH-1:0]   result_q;
  reg                zero_q;
  wire [WIDTH-1:0]   alu_result;
  wire               alu_zero;

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  nibble_xor_alu #(.WIDTH(WIDTH)) u_alu
  (
    .acc         (acc),
    .operand     (operand),
    .do_exchange (is_swap),
    .result      (alu_result),
    .zero        (alu_zero)
  );

  // direction registers mapped into file space at 5..7; the operand
  // fetch looks at the registered address, which holds the same bits
  // as the instruction word for the whole instruction cycle
  wire dir_hit_a = (file_addr == `DIR_FILE_A);
  wire dir_hit_b = (file_addr == `DIR_FILE_B);
  wire dir_hit_c = (file_addr == `DIR_FILE_C);
  wire dir_hit = dir_hit_a | dir_hit_b | dir_hit_c;
  reg  [WIDTH-1:0] dir_rd;

  // direction register readback replaces external file data
  always @*
  begin
    if (dir_hit_a)
      dir_rd = dir_a;
    else if (dir_hit_b)
      dir_rd = dir_b;
    else
      dir_rd = dir_c;
  end

  // ----------------------------------------------------------------
  // write-back targets
  // ----------------------------------------------------------------
  // file-register results aimed at 5..7 stay inside the block, so the
  // external file never sees a write meant for a direction register;
  // decoded from the held word rather than the address output
  wire dst_dir_a = (faddr == `DIR_FILE_A);
  wire dst_dir_b = (faddr == `DIR_FILE_B);
  wire dst_dir_c = (faddr == `DIR_FILE_C);

  // ----------------------------------------------------------------
  // four-phase sequencer
  // ----------------------------------------------------------------
  // one instruction cycle is four clocks; a new word is taken only
  // in the decode phase, so back-to-back issue costs no extra clocks;
  // there is no ready output: an offer made outside the decode phase
  // is simply not seen, and the fetch side must hold it until then
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase      <= `PHASE_DECODE;
      busy       <= 1'b0;
      cur        <= {`INSN_W{1'b0}};
      operand    <= {WIDTH{1'b0}};
      result_q   <= {WIDTH{1'b0}};
      zero_q     <= 1'b0;
      file_addr  <= 7'h00;
      file_rd    <= 1'b0;
      file_we    <= 1'b0;
      file_wdata <= {WIDTH{1'b0}};
      acc        <= {WIDTH{1'b0}};
      zero_flag  <= 1'b0;
      dir_a      <= `DIR_RESET;
      dir_b      <= `DIR_RESET;
      dir_c      <= `DIR_RESET;
      illegal    <= 1'b0;
    end
    else
    begin
      file_we <= 1'b0;
      file_rd <= 1'b0;
      case (phase)
        `PHASE_DECODE:
        begin
          illegal <= 1'b0;
          if (insn_valid)
          begin
            cur       <= insn;
            file_addr <= insn[`FADDR_HI:`FADDR_LO];
            busy      <= 1'b1;
            phase     <= `PHASE_READ;
          end
          else
            busy <= 1'b0;
        end
        `PHASE_READ:
        begin
          // operand fetch: file, direction register or literal; the
          // file data is good only in this phase, so it is latched now
          // and the read strobe that follows marks a completed read
          if (is_xorl)
            operand <= cur[`LIT_HI:`LIT_LO];
          else if (dir_hit)
            operand <= dir_rd;
          else
          begin
            operand <= file_rdata;
            file_rd <= is_swap | is_xorf;
          end
          illegal <= ~(is_swap | is_xorf | is_xorl | is_dirl);
          phase   <= `PHASE_PROCESS;
        end
        `PHASE_PROCESS:
        begin
          // registered so the write phase works from a settled value
          // while the accumulator feeding the unit may be overwritten
          result_q <= alu_result;
          zero_q   <= alu_zero;
          phase    <= `PHASE_WRITE;
        end
        default:
        begin
          // write-back phase; busy and illegal drop here so that both
          // end with the instruction, not with the next decode
          busy    <= 1'b0;
          illegal <= 1'b0;
          if (is_dirl)
          begin
            // old loading form; direct writes are preferred by code
            if (dsel == `DIR_SEL_FIRST)
              dir_a <= acc;
            else if (dsel == `DIR_SEL_MID)
              dir_b <= acc;
            else
              dir_c <= acc;
          end
          else if (is_xorl)
          begin
            acc       <= result_q;
            zero_flag <= zero_q;
          end
          else if (is_swap | is_xorf)
          begin
            // the exchange leaves every status flag as it was
            if (is_xorf)
              zero_flag <= zero_q;
            if (!to_file)
              acc <= result_q;
            else if (dst_dir_a)
              dir_a <= result_q;
            else if (dst_dir_b)
              dir_b <= result_q;
            else if (dst_dir_c)
              dir_c <= result_q;
            else
            begin
              file_we    <= 1'b1;
              file_wdata <= result_q;
            end
          end
          phase <= `PHASE_DECODE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* include/exec_defs.vh */
`ifndef EXEC_DEFS_VH
`define EXEC_DEFS_VH

// instruction word layout (14-bit)
`define INSN_W          14
`define OPC_HI          13
`define OPC_LO          8
`define DEST_BIT        7
`define FADDR_HI        6
`define FADDR_LO        0
`define LIT_HI          7
`define LIT_LO          0
`define DIR_SEL_HI      2
`define DIR_SEL_LO      0

// opcode patterns, bits 13:8
`define OPC_NIBBLE_EXCHANGE 6'h0e
`define OPC_XOR_FILE        6'h06
`define OPC_XOR_LITERAL     6'h3a
// direction-load full pattern: bits 13:3
`define DIR_LOAD_HI         13
`define DIR_LOAD_LO         3
`define DIR_LOAD_PATTERN    11'h00c
`define DIR_SEL_FIRST       3'h5
`define DIR_SEL_MID         3'h6
`define DIR_SEL_LAST        3'h7

// port direction registers in file space
`define DIR_FILE_A          7'h05
`define DIR_FILE_B          7'h06
`define DIR_FILE_C          7'h07
`define DIR_RESET           8'hff

// phase codes
`define PHASE_DECODE        2'h0
`define PHASE_READ          2'h1
`define PHASE_PROCESS       2'h2
`define PHASE_WRITE         2'h3

`endif

/* rtl/nibble_xor_alu.v */
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.vh"

module nibble_xor_alu
#(
  parameter WIDTH = 8
)
(
  input  wire [WIDTH-1:0] acc,
  input  wire [WIDTH-1:0] operand,
  input  wire             do_exchange,
  output reg  [WIDTH-1:0] result,
  output wire             zero
);

  localparam HALF = WIDTH / 2;

  // exchange halves, or xor accumulator with the operand
  always @*
  begin
    if (do_exchange)
      result = {operand[HALF-1:0], operand[WIDTH-1:HALF]};
    else
      result = acc ^ operand;
  end

  assign zero = (result == {WIDTH{1'b0}});

endmodule

`default_nettype wire

/* dv/exec_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// exec checker
// ----
module exec_props (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        insn_valid,
  input wire logic [13:0] insn,
  input wire logic [7:0]  file_rdata,
  input wire logic [6:0]  file_addr,
  input wire logic        file_rd,
  input wire logic        file_we,
  input wire logic [7:0]  file_wdata,
  input wire logic [7:0]  acc,
  input wire logic        zero_flag,
  input wire logic [7:0]  dir_b,
  input wire logic [1:0]  phase,
  input wire logic        busy,
  input wire logic        illegal
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // take edge and decoded kinds
  wire       tk = phase == 2'h0 && insn_valid;
  wire       sw = tk && insn[13:8] == 6'h0e;
  wire       xf = tk && insn[13:8] == 6'h06 && insn[6:0] > 7'h07;
  wire       xl = tk && insn[13:8] == 6'h3a;
  wire [7:0] rsw = {file_rdata[3:0], file_rdata[7:4]};
  AST_STEP: assert property (
    phase != 2'h0 |=> phase == $past(phase) + 2'h1)
    else $error("phase skipped");
  AST_IDLE: assert property (
    phase == 2'h0 && !insn_valid |=> phase == 2'h0)
    else $error("start without offer");
  AST_XORL: assert property (
    xl |-> ##4 acc == ($past(acc, 4) ^ $past(insn[7:0], 4)))
    else $error("xor literal wrong");
  AST_ZERO: assert property (
    xl |-> ##4 zero_flag == (acc == 8'h00))
    else $error("zero flag wrong");
  AST_SWFLAG: assert property (
    sw |-> ##4 zero_flag == $past(zero_flag, 4))
    else $error("exchange touched flag");
  AST_SWWR: assert property (
    sw && insn[7] && insn[6:0] > 7'h07
    |-> ##4 file_we && file_wdata == $past(rsw, 3))
    else $error("exchange write wrong");
  AST_XKEEP: assert property (
    xf && insn[7] |-> ##4 acc == $past(acc, 4))
    else $error("acc changed");
  AST_XACC: assert property (
    xf && !insn[7]
    |-> ##4 acc == ($past(acc, 4) ^ $past(file_rdata, 3)) && !file_we)
    else $error("xor file to acc wrong");
  AST_DIR: assert property (
    tk && insn == 14'h0066 |-> ##4 dir_b == $past(acc, 4))
    else $error("direction load wrong");
  AST_BAD: assert property (
    tk && insn[13:3] == 11'h00c && insn[2:0] < 3'h5 |-> ##2 illegal)
    else $error("bad select not flagged");
  AST_FADDR: assert property (
    tk |=> file_addr == $past(insn[6:0]))
    else $error("file address not taken");
  AST_FRD: assert property (
    (xf || (sw && insn[6:0] > 7'h07)) |-> ##2 file_rd)
    else $error("file read strobe missing");
  AST_NORD: assert property (
    xl |-> ##2 !file_rd)
    else $error("literal op read the file");
  AST_BUSY: assert property (
    busy == (phase != 2'h0))
    else $error("busy out of step with phase");
  C_SW: cover property (sw && insn[7]);
  C_DIR: cover property (tk && insn == 14'h0066);
  C_ZERO: cover property (xl ##4 zero_flag);
  C_XF: cover property (xf && !insn[7]);
endmodule
bind nibble_swap_xor_dir_exec exec_props exec_props_inst (.*);
`default_nettype wire

/* dv/file_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// core register file model
// ----
module file_partner (
  input wire logic       clk,
  input wire logic [6:0] file_addr,
  input wire logic [1:0] phase,
  input wire logic       file_we,
  input wire logic [7:0] file_wdata,
  output logic [7:0]     file_rdata
);
  logic [7:0] mem [0:127];
  // data only good in read phase; inverse elsewhere so stale use shows
  assign file_rdata = phase == 2'h1 ? mem[file_addr] : ~mem[file_addr];
  always @(posedge clk)
    if (file_we)
      mem[file_addr] <= file_wdata;
endmodule
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// random instruction stream
// ----
module tb_top;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        insn_valid = 1'b0;
  logic [13:0] insn = 14'h0000;
  wire  [7:0]  file_rdata, file_wdata, acc, dir_a, dir_b, dir_c;
  wire  [6:0]  file_addr;
  wire  [1:0]  phase;
  wire         file_rd, file_we, zero_flag, busy, illegal;
  logic [7:0]  m [0:127];
  logic [7:0]  ed [0:2];
  logic [7:0]  ea, op, res, lit;
  logic [6:0]  a;
  logic        ez, we, dr;
  logic [41:0] q [$];
  logic [1:0]  ph_q;
  logic [31:0] s = 32'h55;
  int          n_fail = 0;
  int          compares = 0;
  nibble_swap_xor_dir_exec nibble_swap_xor_dir_exec_inst (.*);
  file_partner file_partner_inst (.*);
  initial forever #10 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic check(input logic [41:0] want, got);
    compares++;
    if (got !== want)
    begin
      n_fail++;
      $display("mismatch %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // result lands on the step from write phase back to decode
  wire [41:0] got = {acc, zero_flag, dir_a, dir_b, dir_c, file_we,
                     file_we ? file_wdata : 8'h00};
  always @(posedge clk) ph_q <= phase;
  always @(negedge clk)
    if (rstn && ph_q == 2'h3 && phase == 2'h0 && q.size() != 0)
      check(q.pop_front(), got);
    else if (rstn && ph_q == 2'h3 && phase == 2'h0)
    begin
      n_fail++;
      $display("mismatch %0t: result with no note", $time);
    end
  // bench model runs in step with the driver
  initial
  begin
    for (int i = 0; i < 128; i++) m[i] = 8'(i * 37);
    for (int i = 0; i < 128; i++) file_partner_inst.mem[i] = m[i];
    ea = 8'h00;
    ez = 1'b0;
    ed = '{3{8'hff}};
    repeat (5) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1; // five rising edges seen with reset low
    repeat (300)
    begin
      @(negedge clk);
      s = xs(s);
      if (s[31])
      begin
        insn_valid = 1'b0;
        repeat (4) @(negedge clk);
      end
      a = s[8] ? 7'h05 + 7'(s[10:9] % 3) : s[6:0];
      dr = a >= 7'h05 && a <= 7'h07;
      op = dr ? ed[a - 7'h05] : m[a];
      lit = s[14] ? ea : s[27:20];
      we = 1'b0;
      case (s[13:11] % 5)
        0: insn = {6'h0e, s[7], a};
        1: insn = {6'h06, s[7], a};
        2: insn = {6'h3a, lit};
        3: insn = {11'h00c, s[16:14]};
        default: insn = 14'h3fff;
      endcase
      res = insn[13:8] == 6'h06 ? ea ^ op : {op[3:0], op[7:4]};
      if (insn[13:8] == 6'h3a)
      begin
        ea = ea ^ lit;
        ez = ea == 8'h00;
      end
      else if (insn[13:3] == 11'h00c && s[16:14] >= 3'h5)
        ed[s[16:14] - 3'h5] = ea;
      else if (insn[13:8] == 6'h0e || insn[13:8] == 6'h06)
      begin
        if (insn[13:8] == 6'h06) ez = res == 8'h00;
        if (!s[7]) ea = res;
        else if (dr) ed[a - 7'h05] = res;
        else
        begin
          we = 1'b1;
          m[a] = res;
        end
      end
      q.push_back({ea, ez, ed[0], ed[1], ed[2], we, we ? res : 8'h00});
      insn_valid = 1'b1;
      repeat (3) @(negedge clk);
    end
    // withdraw the offer so the last word is not taken a second time
    @(negedge clk);
    insn_valid = 1'b0;
    repeat (6) @(negedge clk);
    if (q.size() != 0)
    begin
      n_fail++;
      $display("mismatch %0t: %0d results never came", $time, q.size());
    end
    give_verdict;
  end
  initial
  begin
    #100000;
    n_fail++;
    give_verdict;
  end
endmodule
`default_nettype wire
